/* File: rtl/drv_pkg.sv */
package drv_pkg;

    // ========================================================
    // sizes
    localparam int NOUT = 7;
    localparam int NHB = 3;
    localparam int NPWM = 4;
    localparam int NFLT = 19;

    // ========================================================
    // timing
    localparam int CLK_NS = 25;
    localparam int CLK_HZ = 40000000;
    localparam int T_FOC_NS = 10000;
    localparam int T_FOL_NS = 50000;
    localparam int T_SUP_NS = 20000;
    localparam int T_JTFT_NS = 32000;
    localparam int T_CP_NS = 64000;
    localparam int T_CMBLANK_NS = 32000;
    localparam int T_XC_NS = 10000;
    localparam int PWM_F_LO_HZ = 122;
    localparam int PWM_F_HI_HZ = 244;
    localparam int PWM_STEPS = 128;
    localparam logic [11:0] FOC_CYC = 12'((T_FOC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] FOL_CYC = 12'((T_FOL_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] SUP_CYC = 12'((T_SUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] JTFT_CYC = 12'((T_JTFT_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] CP_CYC = 12'((T_CP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] CMBLANK_CYC = 12'((T_CMBLANK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] XC_CYC = 12'((T_XC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] STEP_LO_CYC = 12'(CLK_HZ / (PWM_F_LO_HZ * PWM_STEPS));
    localparam logic [11:0] STEP_HI_CYC = 12'(CLK_HZ / (PWM_F_HI_HZ * PWM_STEPS));

    // ========================================================
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_BRIDGE = 8'h04;
    localparam logic [7:0] REG_DUTY = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_SWRESET = 8'h14;
    localparam logic [7:0] REG_DRIVE = 8'h18;
    localparam logic [7:0] REG_STATUS_RC = 8'h1C;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] BRIDGE_RST = 32'h0000_0000;
    localparam logic [31:0] DUTY_RST = 32'h0000_0000;

    // ========================================================
    // field positions
    localparam int CTRL_ON_LSB = 0;
    localparam int CTRL_PWMEN_LSB = 7;
    localparam int CTRL_REC_LSB = 14;
    localparam int CTRL_INHIBIT_BIT = 21;
    localparam int CTRL_FSEL_BIT = 22;
    localparam int CTRL_CMSEL_LSB = 24;
    localparam int DUTY_STRIDE = 8;
    localparam int ST_OC_LSB = 0;
    localparam int ST_OL_LSB = 7;
    localparam int ST_OV = 14;
    localparam int ST_UV = 15;
    localparam int ST_TW = 16;
    localparam int ST_TSD = 17;
    localparam int ST_CP = 18;
    localparam int SWRST_BIT = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // bit i of the packed form matches filter/status index i
    typedef struct packed {
        logic vcc_high;
        logic vcc_low;
        logic charge_pump_low_flag;
        logic tsd;
        logic tw;
        logic vs_uv;
        logic vs_ov;
        logic [6:0] ol;
        logic [6:0] oc;
    } drv_sense_t;

    typedef struct packed {
        logic cm_en;
        logic gate_rlow;
        logic gate_sink;
        logic cp_en;
        logic out_hiz;
        logic [2:0] ls_on;
        logic [6:0] hs_on;
    } drv_drive_t;

endpackage : drv_pkg

/* File: rtl/drv_protect.sv */
// Notes on behaviour
// - each fault condition must persist for its filter time before its flag sets
// - open-load and warning flags never change any driver state
// - overcurrent stops its own driver; thermal shutdown stops all drivers
// - overvoltage: outputs high impedance, charge pump off, gates sinking
// - undervoltage: power outputs high impedance
// - supply back and inhibit clear: pump on, pump-low cleared, outputs restored
// - inhibit set: no automatic restart, software clears flags to restart
// - logic supply low: outputs off and status cleared; rise reinitialises
// - logic supply too high: reset with outputs off, registers cleared
// - warning flag sets after overtemperature lasts the filter time
// - shutdown flag sets after filter time, all stages off, gates resistive low
// - thermal flags latch; a read-and-clear command clears them
// - clearing restarts outputs; shutdown needs warning flag first, two filter times
// - open-load flag sets when active output current stays low for filter time
// - overcurrent lasting the filter time sets flag and stops that driver
// - four-bit select field picks output routed to current image
// - current image off while selected output off, on after blanking time
// - with pwm enabled output is control bit and pwm signal
// - one shared setting picks 122 Hz or 244 Hz pwm
// - four 7-bit duty counters, step 100/128 percent, max one step short
// - half bridge waits cross-current time before turning opposite switch on
// - pump-low flag latches until software reset command, logic supply reset, or supply back with inhibit clear
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module drv_protect (
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire drv_pkg::drv_sense_t i_sense,
    output var drv_pkg::drv_drive_t o_drive,
    output logic [3:0] o_monitor_output_select,
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);

    // ========================================================
    // input synchronisers
    drv_pkg::drv_sense_t sync1_ff;
    drv_pkg::drv_sense_t sync2_ff;
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= i_sense;
            sync2_ff <= sync1_ff;
        end
    end

    // ========================================================
    // registers
    logic [31:0] ctrl_ff;
    logic [31:0] bridge_ff;
    logic [31:0] duty_ff;
    logic [drv_pkg::NFLT-1:0] flags_ff;
    logic [drv_pkg::NFLT-1:0] clr_mask_ff;
    logic swrst_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic wr_go;
    logic rd_go;
    logic [31:0] rd_mux;
    logic map_ok;
    logic soft_clr;
    logic [6:0] hs_vec;
    logic [2:0] ls_vec;

    assign soft_clr = sync2_ff.vcc_low | sync2_ff.vcc_high | swrst_ff;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int k = 0; k < 4; k++) begin
            if (s[k]) begin
                r[k*8 +: 8] = d[k*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        map_ok = 1'b1;
        rd_mux = 32'h0000_0000;
        case (i_araddr)
            drv_pkg::REG_CTRL: rd_mux = ctrl_ff;
            drv_pkg::REG_BRIDGE: rd_mux = bridge_ff;
            drv_pkg::REG_DUTY: rd_mux = duty_ff;
            drv_pkg::REG_STATUS: rd_mux = 32'(flags_ff);
            drv_pkg::REG_STATUS_RC: rd_mux = 32'(flags_ff);
            drv_pkg::REG_SWRESET: rd_mux = 32'h0000_0000;
            drv_pkg::REG_DRIVE: rd_mux = 32'(o_drive);
            default: map_ok = 1'b0;
        endcase
    end

    // ========================================================
    // axi4-lite slave
    assign wr_go = !o_awready && !o_wready && !o_bvalid;
    assign rd_go = i_arvalid && o_arready;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= drv_pkg::RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                o_awready <= 1'b0;
                awaddr_ff <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                o_wready <= 1'b0;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (wr_go) begin
                o_bvalid <= 1'b1;
                o_bresp <= (awaddr_ff == drv_pkg::REG_CTRL || awaddr_ff == drv_pkg::REG_BRIDGE
                    || awaddr_ff == drv_pkg::REG_DUTY || awaddr_ff == drv_pkg::REG_STATUS
                    || awaddr_ff == drv_pkg::REG_SWRESET) ? drv_pkg::RESP_OKAY
                    : drv_pkg::RESP_SLVERR;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= drv_pkg::RESP_OKAY;
        end else begin
            if (rd_go) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_mux;
                o_rresp <= map_ok ? drv_pkg::RESP_OKAY : drv_pkg::RESP_SLVERR;
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    // control registers; software reset and supply resets clear them
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_ff <= drv_pkg::CTRL_RST;
            bridge_ff <= drv_pkg::BRIDGE_RST;
            duty_ff <= drv_pkg::DUTY_RST;
            swrst_ff <= 1'b0;
        end else if (soft_clr) begin
            ctrl_ff <= drv_pkg::CTRL_RST;
            bridge_ff <= drv_pkg::BRIDGE_RST;
            duty_ff <= drv_pkg::DUTY_RST;
            swrst_ff <= 1'b0;
        end else begin
            swrst_ff <= wr_go && awaddr_ff == drv_pkg::REG_SWRESET && wstrb_ff[0]
                && wdata_ff[drv_pkg::SWRST_BIT];
            if (wr_go && awaddr_ff == drv_pkg::REG_CTRL) begin
                ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
            end
            if (wr_go && awaddr_ff == drv_pkg::REG_BRIDGE) begin
                bridge_ff <= merge(bridge_ff, wdata_ff, wstrb_ff);
            end
            if (wr_go && awaddr_ff == drv_pkg::REG_DUTY) begin
                duty_ff <= merge(duty_ff, wdata_ff, wstrb_ff);
            end
        end
    end

    // clear requests: write-one-to-clear, or read of the read-and-clear alias
    logic [31:0] wr_bits;
    assign wr_bits = merge(32'h0000_0000, wdata_ff, wstrb_ff);

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            clr_mask_ff <= '0;
        end else begin
            clr_mask_ff <= '0;
            if (wr_go && awaddr_ff == drv_pkg::REG_STATUS) begin
                clr_mask_ff <= wr_bits[drv_pkg::NFLT-1:0];
            end
            if (rd_go && i_araddr == drv_pkg::REG_STATUS_RC) begin
                clr_mask_ff <= '1;
            end
            clr_mask_ff[drv_pkg::ST_CP] <= 1'b0;
        end
    end

    // ========================================================
    // fault filters
    logic [drv_pkg::NFLT-1:0] cond;
    logic [drv_pkg::NFLT-1:0] live;
    logic [drv_pkg::NFLT-1:0] hit;
    logic [11:0] flt_cnt_ff [drv_pkg::NFLT];

    function automatic logic [11:0] filt_tc(input int idx);
        if (idx < drv_pkg::ST_OL_LSB) return drv_pkg::FOC_CYC;
        else if (idx < drv_pkg::ST_OV) return drv_pkg::FOL_CYC;
        else if (idx < drv_pkg::ST_TW) return drv_pkg::SUP_CYC;
        else if (idx == drv_pkg::ST_CP) return drv_pkg::CP_CYC;
        else return drv_pkg::JTFT_CYC;
    endfunction : filt_tc

    always_comb begin
        cond = sync2_ff[drv_pkg::NFLT-1:0];
        cond[drv_pkg::ST_OL_LSB +: 7] = sync2_ff.ol & (hs_vec | {4'h0, ls_vec});
        cond[drv_pkg::ST_TSD] = sync2_ff.tsd && flags_ff[drv_pkg::ST_TW];
    end

    for (genvar g = 0; g < drv_pkg::NFLT; g++) begin : g_filt
        always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                flt_cnt_ff[g] <= 12'h000;
            end else if (!cond[g] || soft_clr) begin
                flt_cnt_ff[g] <= 12'h000;
            end else if (clr_mask_ff[g] && (g == drv_pkg::ST_TW || g == drv_pkg::ST_TSD)) begin
                // thermal flags refilter after a clear while still hot
                flt_cnt_ff[g] <= 12'h000;
            end else if (flt_cnt_ff[g] != filt_tc(g)) begin
                flt_cnt_ff[g] <= flt_cnt_ff[g] + 12'h001;
            end
        end
        assign live[g] = flt_cnt_ff[g] == filt_tc(g);
        assign hit[g] = cond[g] && flt_cnt_ff[g] == filt_tc(g) - 12'h001;
    end

    // ========================================================
    // latched flags; a set in the clear cycle wins
    logic sup_bad;
    logic sup_bad_d_ff;
    logic inhibit;
    logic recover;
    logic [drv_pkg::NFLT-1:0] set_v;
    assign sup_bad = live[drv_pkg::ST_OV] || live[drv_pkg::ST_UV];
    assign inhibit = ctrl_ff[drv_pkg::CTRL_INHIBIT_BIT];
    assign recover = sup_bad_d_ff && !sup_bad && !inhibit;

    always_comb begin
        set_v = hit;
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            flags_ff <= '0;
            sup_bad_d_ff <= 1'b0;
        end else if (soft_clr) begin
            flags_ff <= '0;
            sup_bad_d_ff <= 1'b0;
        end else begin
            sup_bad_d_ff <= sup_bad;
            flags_ff <= (flags_ff & ~clr_mask_ff) | set_v;
            if (recover && !set_v[drv_pkg::ST_CP]) begin
                flags_ff[drv_pkg::ST_CP] <= 1'b0;
            end
        end
    end

    // ========================================================
    // pwm generator
    logic [11:0] presc_ff;
    logic [6:0] pwm_cnt_ff;
    logic [11:0] step_cyc;
    logic [drv_pkg::NPWM-1:0] pwm_sig;
    assign step_cyc = ctrl_ff[drv_pkg::CTRL_FSEL_BIT] ? drv_pkg::STEP_HI_CYC
        : drv_pkg::STEP_LO_CYC;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            presc_ff <= 12'h000;
            pwm_cnt_ff <= 7'h00;
        end else if (presc_ff >= step_cyc - 12'h001) begin
            presc_ff <= 12'h000;
            pwm_cnt_ff <= pwm_cnt_ff + 7'h01;
        end else begin
            presc_ff <= presc_ff + 12'h001;
        end
    end

    for (genvar p = 0; p < drv_pkg::NPWM; p++) begin : g_pwm
        assign pwm_sig[p] = pwm_cnt_ff < duty_ff[p*drv_pkg::DUTY_STRIDE +: 7];
    end

    // ========================================================
    // driver enables
    logic all_off;
    logic [6:0] oc_kill;
    logic [6:0] want_hs;
    logic [2:0] want_ls;
    logic [6:0] on_bits;
    logic [6:0] pwm_en;
    logic [6:0] rec_bits;
    assign on_bits = ctrl_ff[drv_pkg::CTRL_ON_LSB +: 7];
    assign pwm_en = ctrl_ff[drv_pkg::CTRL_PWMEN_LSB +: 7];
    assign rec_bits = ctrl_ff[drv_pkg::CTRL_REC_LSB +: 7];
    // open-load and warning flags deliberately absent here
    assign all_off = flags_ff[drv_pkg::ST_TSD] || flags_ff[drv_pkg::ST_CP] || sup_bad
        || (inhibit && (flags_ff[drv_pkg::ST_OV] || flags_ff[drv_pkg::ST_UV]))
        || soft_clr;
    assign oc_kill = (flags_ff[6:0] & ~rec_bits) | live[6:0];

    for (genvar i = 0; i < drv_pkg::NOUT; i++) begin : g_want
        assign want_hs[i] = on_bits[i] && (!pwm_en[i] || pwm_sig[i % drv_pkg::NPWM])
            && !oc_kill[i] && !all_off;
    end
    for (genvar b = 0; b < drv_pkg::NHB; b++) begin : g_wantl
        assign want_ls[b] = bridge_ff[b] && !on_bits[b] && !oc_kill[b] && !all_off;
    end

    // ========================================================
    // half bridges with cross-current delay
    logic hb_hs_ff [drv_pkg::NHB];
    logic hb_ls_ff [drv_pkg::NHB];
    logic [11:0] dead_ff [drv_pkg::NHB];
    logic [3:0] hs_hi_ff;

    for (genvar b = 0; b < drv_pkg::NHB; b++) begin : g_hb
        always_ff @(posedge i_sys_clk or negedge i_rstn) begin
            if (!i_rstn) begin
                hb_hs_ff[b] <= 1'b0;
                hb_ls_ff[b] <= 1'b0;
                dead_ff[b] <= 12'h000;
            end else begin
                hb_hs_ff[b] <= want_hs[b] && (hb_hs_ff[b]
                    || (!hb_ls_ff[b] && dead_ff[b] == 12'h000));
                hb_ls_ff[b] <= want_ls[b] && (hb_ls_ff[b]
                    || (!hb_hs_ff[b] && dead_ff[b] == 12'h000));
                if ((hb_hs_ff[b] && !want_hs[b]) || (hb_ls_ff[b] && !want_ls[b])) begin
                    dead_ff[b] <= drv_pkg::XC_CYC;
                end else if (dead_ff[b] != 12'h000) begin
                    dead_ff[b] <= dead_ff[b] - 12'h001;
                end
            end
        end
        assign ls_vec[b] = hb_ls_ff[b];
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            hs_hi_ff <= 4'h0;
        end else begin
            hs_hi_ff <= want_hs[6:3];
        end
    end

    assign hs_vec = {hs_hi_ff, hb_hs_ff[2], hb_hs_ff[1], hb_hs_ff[0]};

    // ========================================================
    // supply, charge pump, gate modes, current image
    logic cp_en_ff;
    logic sink_ff;
    logic rlow_ff;
    logic hiz_ff;
    logic cm_en_ff;
    logic [3:0] monitor_output_select_d_ff;
    logic [11:0] blank_ff;
    logic [3:0] monitor_output_select;
    logic cm_src_on;
    assign monitor_output_select = ctrl_ff[drv_pkg::CTRL_CMSEL_LSB +: 4];
    assign cm_src_on = (monitor_output_select < 4'h7) && hs_vec[monitor_output_select[2:0]];

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cp_en_ff <= 1'b0;
            sink_ff <= 1'b0;
            rlow_ff <= 1'b0;
            hiz_ff <= 1'b1;
        end else begin
            cp_en_ff <= !live[drv_pkg::ST_OV] && !flags_ff[drv_pkg::ST_TSD]
                && !(inhibit && flags_ff[drv_pkg::ST_OV]) && !soft_clr;
            sink_ff <= live[drv_pkg::ST_OV];
            rlow_ff <= flags_ff[drv_pkg::ST_TSD] || flags_ff[drv_pkg::ST_CP];
            hiz_ff <= all_off;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            monitor_output_select_d_ff <= 4'h0;
            blank_ff <= 12'h000;
            cm_en_ff <= 1'b0;
        end else begin
            monitor_output_select_d_ff <= monitor_output_select;
            if (!cm_src_on || monitor_output_select != monitor_output_select_d_ff) begin
                blank_ff <= 12'h000;
                cm_en_ff <= 1'b0;
            end else if (blank_ff == drv_pkg::CMBLANK_CYC) begin
                cm_en_ff <= 1'b1;
            end else begin
                blank_ff <= blank_ff + 12'h001;
            end
        end
    end

    assign o_monitor_output_select = monitor_output_select_d_ff;
    assign o_drive = '{cm_en: cm_en_ff, gate_rlow: rlow_ff, gate_sink: sink_ff,
        cp_en: cp_en_ff, out_hiz: hiz_ff, ls_on: ls_vec, hs_on: hs_vec};

    // ========================================================
    // checks
    tsd_all_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        flags_ff[drv_pkg::ST_TSD] |=> (o_drive.hs_on == 7'h00 && o_drive.ls_on == 3'h0
        && o_drive.gate_rlow)) else $error("drivers on under thermal shutdown");
    ov_protect_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        live[drv_pkg::ST_OV] |=> (o_drive.out_hiz && o_drive.gate_sink && !o_drive.cp_en))
        else $error("overvoltage not protected");
    uv_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        live[drv_pkg::ST_UV] |=> (o_drive.out_hiz && o_drive.hs_on == 7'h00))
        else $error("undervoltage outputs active");
    oc_driver_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        ##1 (o_drive.hs_on & $past(flags_ff[6:0] & ~rec_bits)) == 7'h00)
        else $error("driver on with latched overcurrent");
    filter_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $rose(flags_ff[drv_pkg::ST_TW]) |-> $past(flt_cnt_ff[drv_pkg::ST_TW])
        == drv_pkg::JTFT_CYC - 12'h001) else $error("warning set before filter time");
    dead_time_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        $fell(hb_ls_ff[0]) |-> !hb_hs_ff[0] [*8]) else $error("cross-current delay broken");
    cm_hiz_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !cm_src_on |=> !o_drive.cm_en) else $error("current image on while output off");
    cp_latch_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (flags_ff[drv_pkg::ST_CP] && !soft_clr && !recover) |=> flags_ff[drv_pkg::ST_CP])
        else $error("pump-low flag lost");
    por_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        sync2_ff.vcc_low |=> (flags_ff == '0 && o_drive.out_hiz))
        else $error("logic supply low not cleared");

endmodule : drv_protect
`default_nettype wire

/* File: tb/drv_load.sv */
`timescale 1ns/1ps
`default_nettype none
// load side: current faults only show on outputs whose high-side switch is on
module drv_load (
    input wire logic i_sys_clk,
    input wire drv_pkg::drv_drive_t i_drive,
    input wire drv_pkg::drv_sense_t i_fault,
    output var drv_pkg::drv_sense_t o_sense
);
    always_ff @(posedge i_sys_clk) begin
        o_sense <= i_fault;
        o_sense.oc <= i_fault.oc & i_drive.hs_on;
        o_sense.ol <= i_fault.ol & i_drive.hs_on;
    end
endmodule : drv_load
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic i_sys_clk = 1'h0;
    logic i_rstn = 1'h0;
    drv_pkg::drv_sense_t inj = '0;
    drv_pkg::drv_sense_t sense;
    drv_pkg::drv_drive_t drive;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rs;
    logic [3:0] cmsel;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    drv_load u_drv_load (.i_sys_clk(i_sys_clk), .i_drive(drive), .i_fault(inj), .o_sense(sense));
    drv_protect u_drv_protect (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_sense(sense),
        .o_drive(drive), .o_monitor_output_select(cmsel), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'h1),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'h1));
    initial begin
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            summarize();
        end
    end
    // ========================================================
    // report, wait, check and bus tasks
    task summarize();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task w(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask : w
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        do begin
            @(posedge i_sys_clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        rs = bresp;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        araddr <= a;
        arvalid <= 1'h1;
        do begin
            @(posedge i_sys_clk);
            if (arready) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        rs = rresp;
        chk(rdata & m, e);
    endtask : rd
    // ========================================================
    // scenarios
    initial begin
        w(20);
        i_rstn <= 1'h1;
        w(2);
        rd(drv_pkg::REG_CTRL, 32'hFFFFFFFF, drv_pkg::CTRL_RST);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        chk(32'(rs), 32'(drv_pkg::RESP_SLVERR));
        wr(drv_pkg::REG_CTRL, 32'h1);
        chk(32'(rs), 32'(drv_pkg::RESP_OKAY));
        wr(drv_pkg::REG_DRIVE, 32'h0);
        chk(32'(rs), 32'(drv_pkg::RESP_SLVERR));
        w(4);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        inj.oc[0] <= 1'h1;
        w(drv_pkg::FOC_CYC + 10);
        rd(drv_pkg::REG_STATUS, 32'h1, 32'h1);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h0);
        inj.oc[0] <= 1'h0;
        w(20);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h0);
        wr(drv_pkg::REG_STATUS, 32'h1);
        w(drv_pkg::XC_CYC + 4);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        inj.ol[0] <= 1'h1;
        w(drv_pkg::FOL_CYC + 10);
        rd(drv_pkg::REG_STATUS, 32'h80, 32'h80);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        inj.ol[0] <= 1'h0;
        inj.tw <= 1'h1;
        inj.tsd <= 1'h1;
        w(drv_pkg::JTFT_CYC + 10);
        rd(drv_pkg::REG_STATUS, 32'h30000, 32'h10000);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        w(drv_pkg::JTFT_CYC);
        rd(drv_pkg::REG_DRIVE, 32'h2001, 32'h2000);
        rd(drv_pkg::REG_STATUS_RC, 32'h30000, 32'h30000);
        rd(drv_pkg::REG_STATUS, 32'h30000, 32'h0);
        w(drv_pkg::XC_CYC);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        w(drv_pkg::JTFT_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h1);
        w(drv_pkg::JTFT_CYC);
        rd(drv_pkg::REG_DRIVE, 32'h1, 32'h0);
        inj.tw <= 1'h0;
        inj.tsd <= 1'h0;
        rd(drv_pkg::REG_STATUS_RC, 32'h0, 32'h0);
        inj.vs_ov <= 1'h1;
        w(drv_pkg::SUP_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h1C00, 32'h1400);
        inj.vs_ov <= 1'h0;
        w(2 * drv_pkg::SUP_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h0C01, 32'h0801);
        wr(drv_pkg::REG_STATUS, 32'h4000);
        wr(drv_pkg::REG_CTRL, 32'h200001);
        inj.vs_uv <= 1'h1;
        w(drv_pkg::SUP_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h400, 32'h400);
        inj.vs_uv <= 1'h0;
        w(2 * drv_pkg::SUP_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h401, 32'h400);
        wr(drv_pkg::REG_STATUS, 32'h8000);
        w(4);
        rd(drv_pkg::REG_DRIVE, 32'h401, 32'h1);
        wr(drv_pkg::REG_CTRL, 32'h0);
        wr(drv_pkg::REG_BRIDGE, 32'h1);
        rd(drv_pkg::REG_DRIVE, 32'h81, 32'h0);
        w(drv_pkg::XC_CYC);
        rd(drv_pkg::REG_DRIVE, 32'h81, 32'h80);
        inj.charge_pump_low_flag <= 1'h1;
        w(drv_pkg::CP_CYC + 10);
        rd(drv_pkg::REG_DRIVE, 32'h2080, 32'h2000);
        rd(drv_pkg::REG_STATUS_RC, 32'h40000, 32'h40000);
        inj.charge_pump_low_flag <= 1'h0;
        rd(drv_pkg::REG_STATUS, 32'h40000, 32'h40000);
        wr(drv_pkg::REG_SWRESET, 32'h1);
        rd(drv_pkg::REG_STATUS, 32'h40000, 32'h0);
        rd(drv_pkg::REG_BRIDGE, 32'hFFFFFFFF, drv_pkg::BRIDGE_RST);
        wr(drv_pkg::REG_DUTY, 32'h7F);
        wr(drv_pkg::REG_CTRL, 32'h0400_0810);
        w(4);
        chk(32'(cmsel), 32'h4);
        rd(drv_pkg::REG_DRIVE, 32'h4010, 32'h0010);
        w(drv_pkg::CMBLANK_CYC);
        rd(drv_pkg::REG_DRIVE, 32'h4010, 32'h4010);
        wr(drv_pkg::REG_DUTY, 32'h0);
        w(4);
        rd(drv_pkg::REG_DRIVE, 32'h4010, 32'h0);
        inj.vcc_low <= 1'h1;
        w(4);
        rd(drv_pkg::REG_DRIVE, 32'h400, 32'h400);
        rd(drv_pkg::REG_CTRL, 32'hFFFFFFFF, drv_pkg::CTRL_RST);
        inj.vcc_low <= 1'h0;
        summarize();
    end
endmodule : tb
`default_nettype wire
